// *** core/hsm_map.svh ***
// constants of the hall sensor mode and interrupt controller
// Functional notes
// - interrupt signalled on the interrupt pin or by pulling the clock line low
// - routing 000 none, 001 pin, 010 pin unless busy, 011 clock, 100 clock unless busy
// - completed conversion skips result and set count update while addressed, or busy in 100
// - acknowledge only in standby or continuous measure mode
// - own address wakes a sleeping device, and that byte is not acknowledged
// - after power-up, standby is reached after 270 us
// - after wake from sleep, standby is reached after 50 us
// - standby to continuous measure takes 70 us
// - one channel converts in 50 us at averaging 000 and 825 us at 101
// - sleep entered 20 us after the clock line returns high
// - north pole gives positive codes, south pole negative codes
// - enabled channels share one converter in sequence
// - latch select 1 gives fixed-width pulses, 0 a latched level on the pin routes (the clock routes always pulse)
// - a latched interrupt is cleared only by a valid address on the bus
`ifndef HSM_MAP_SVH
`define HSM_MAP_SVH

`define HSM_CLK_MHZ          200
`define HSM_T_PWRUP_US       270
`define HSM_T_WAKE_US        50
`define HSM_T_MEAS_START_US  70
`define HSM_T_CONV_BASE_US   50
`define HSM_T_CONV_STEP_US   25
`define HSM_T_GOSLEEP_US     20
`define HSM_T_INT_PULSE_US   10
`define HSM_GOSLEEP_CYC      (`HSM_T_GOSLEEP_US * `HSM_CLK_MHZ)
`define HSM_INT_PULSE_CYC    (`HSM_T_INT_PULSE_US * `HSM_CLK_MHZ)
`define HSM_AVG_MAX          3'h5
`define HSM_CH_NONE          3'h4
`define HSM_ADDR_LAST_BIT    4'h7

`endif

// *** core/hsm_pkg.sv ***
// types of the hall sensor mode and interrupt controller
package hsm_pkg;
	typedef enum logic [2:0] {
		HSM_PWRUP      = 3'h0,
		HSM_STANDBY    = 3'h1,
		HSM_START_MEAS = 3'h3,
		HSM_MEASURE    = 3'h2,
		HSM_GO_SLEEP   = 3'h6,
		HSM_SLEEP      = 3'h7,
		HSM_WAKE       = 3'h5
	} hsm_state_t;
	typedef enum logic [2:0] {
		HSM_INT_NONE     = 3'h0,
		HSM_INT_PIN      = 3'h1,
		HSM_INT_PIN_IDLE = 3'h2,
		HSM_INT_SCL      = 3'h3,
		HSM_INT_SCL_IDLE = 3'h4
	} hsm_int_route_t;
	typedef enum logic [1:0] {
		HSM_OP_STANDBY = 2'h0,
		HSM_OP_SLEEP   = 2'h1,
		HSM_OP_CONT    = 2'h2
	} hsm_op_t;
endpackage

// *** core/hsm_ctrl.sv ***
// mode sequencing, bus watch, conversion and interrupt control of the hall sensor
`timescale 1ns/1ps
`include "hsm_map.svh"
module hsm_ctrl import hsm_pkg::*; #(
	parameter int PWRUP_CYC      = `HSM_T_PWRUP_US * `HSM_CLK_MHZ,
	parameter int WAKE_CYC       = `HSM_T_WAKE_US * `HSM_CLK_MHZ,
	parameter int MEAS_START_CYC = `HSM_T_MEAS_START_US * `HSM_CLK_MHZ,
	parameter int CONV_BASE_CYC  = `HSM_T_CONV_BASE_US * `HSM_CLK_MHZ,
	parameter int CONV_STEP_CYC  = `HSM_T_CONV_STEP_US * `HSM_CLK_MHZ
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// i2c pins, open drain
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_scl_out,
	output logic             o_scl_oe,
	output logic             o_sda_out,
	output logic             o_sda_oe,
	// configuration
	input  wire logic [6:0]  i_dev_addr,
	input  wire logic [1:0]  i_op_mode,
	input  wire logic [2:0]  i_int_mode,
	input  wire logic        i_int_latch_sel,
	input  wire logic [2:0]  i_averaging_select,
	input  wire logic [3:0]  i_ch_en,
	input  wire logic        i_trigger,
	input  wire logic        i_event,
	// converter
	input  wire logic [15:0] i_adc_data,
	output logic [1:0]       o_ch_sel,
	output logic             o_conv_busy,
	// status and results
	output logic [15:0]      o_result_x,
	output logic [15:0]      o_result_y,
	output logic [15:0]      o_result_z,
	output logic [15:0]      o_result_t,
	output logic [2:0]       o_set_count,
	output logic [2:0]       o_state,
	output logic             o_int_n
);
	function automatic logic [2:0] next_ch(input logic [3:0] en, input logic [2:0] from);
		logic [2:0] r;
		r = `HSM_CH_NONE;
		for (int i = 3; i >= 0; i--) begin
			if (en[i] && 3'(i) >= from) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [19:0] conv_len(input logic [2:0] avg);
		logic [2:0] a;
		a = (avg > `HSM_AVG_MAX) ? `HSM_AVG_MAX : avg;
		return 20'(CONV_BASE_CYC + CONV_STEP_CYC * ((1 << a) - 1));
	endfunction

	// bus watch
	logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
	logic busy_q, busy_d, talk_q, talk_d, aph_q, aph_d, ackp_q, ackp_d, ack_q, ack_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d;
	logic start, stop, scl_rise, scl_fall, addr_hit, awake;
	hsm_state_t st_q, st_d;

	assign awake = (st_q == HSM_STANDBY) || (st_q == HSM_START_MEAS) || (st_q == HSM_MEASURE);
	assign start = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
	assign stop = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
	assign scl_rise = scl_s_q && !scl_p_q;
	assign scl_fall = !scl_s_q && scl_p_q;
	assign addr_hit = scl_rise && aph_q && bit_q == `HSM_ADDR_LAST_BIT && sh_q[6:0] == i_dev_addr;

	always_comb begin
		busy_d = busy_q;
		talk_d = talk_q;
		aph_d = aph_q;
		ackp_d = ackp_q;
		ack_d = ack_q;
		bit_d = bit_q;
		sh_d = sh_q;
		if (start) begin
			{busy_d, aph_d, talk_d, ackp_d, ack_d} = 5'h18;
			bit_d = 4'h0;
		end else if (stop) begin
			{busy_d, aph_d, talk_d, ackp_d, ack_d} = 5'h00;
		end else begin
			if (scl_rise && aph_q) begin
				sh_d = {sh_q[6:0], sda_s_q};
				bit_d = bit_q + 4'h1;
				if (bit_q == `HSM_ADDR_LAST_BIT) begin
					aph_d = 1'b0;
					talk_d = addr_hit && awake;
					ackp_d = addr_hit && awake;
				end
			end
			// ack held from the falling edge after the address to the next one
			if (scl_fall) begin
				ack_d = ackp_q;
				ackp_d = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q} <= 6'h3F;
			{busy_q, talk_q, aph_q, ackp_q, ack_q} <= 5'h00;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
		end else begin
			{scl_m_q, scl_s_q, scl_p_q} <= {i_scl, scl_m_q, scl_s_q};
			{sda_m_q, sda_s_q, sda_p_q} <= {i_sda, sda_m_q, sda_s_q};
			{busy_q, talk_q, aph_q, ackp_q, ack_q} <= {busy_d, talk_d, aph_d, ackp_d, ack_d};
			bit_q <= bit_d;
			sh_q <= sh_d;
		end
	end

	// mode sequencing
	logic [19:0] tmr_q, tmr_d;
	logic [1:0] op_q;
	logic slp_q, slp_d, sleep_req;

	// sleep is taken on a new command only, so a wake is not undone by a stale mode
	assign sleep_req = slp_q || (i_op_mode == HSM_OP_SLEEP && op_q != HSM_OP_SLEEP);

	always_comb begin
		st_d = st_q;
		tmr_d = tmr_q + 20'h1;
		slp_d = sleep_req && i_op_mode == HSM_OP_SLEEP;
		case (st_q)
			HSM_PWRUP: begin
				if (tmr_q == 20'(PWRUP_CYC - 1)) begin
					st_d = HSM_STANDBY;
				end
			end
			HSM_STANDBY: begin
				if (sleep_req) begin
					st_d = HSM_GO_SLEEP;
					slp_d = 1'b0;
				end else if (i_op_mode == HSM_OP_CONT) begin
					st_d = HSM_START_MEAS;
				end
			end
			HSM_START_MEAS: begin
				if (tmr_q == 20'(MEAS_START_CYC - 1)) begin
					st_d = HSM_MEASURE;
				end
			end
			HSM_MEASURE: begin
				if (sleep_req) begin
					st_d = HSM_GO_SLEEP;
					slp_d = 1'b0;
				end else if (i_op_mode == HSM_OP_STANDBY) begin
					st_d = HSM_STANDBY;
				end
			end
			HSM_GO_SLEEP: begin
				if (!scl_s_q) begin
					tmr_d = 20'h0;
				end else if (tmr_q == 20'(`HSM_GOSLEEP_CYC - 1)) begin
					st_d = HSM_SLEEP;
				end
			end
			HSM_SLEEP: begin
				if (addr_hit) begin
					st_d = HSM_WAKE;
				end
			end
			HSM_WAKE: begin
				if (tmr_q == 20'(WAKE_CYC - 1)) begin
					st_d = HSM_STANDBY;
				end
			end
			default: st_d = HSM_PWRUP;
		endcase
		if (st_d != st_q) begin
			tmr_d = 20'h0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= HSM_PWRUP;
			tmr_q <= 20'h0;
			op_q <= HSM_OP_STANDBY;
			slp_q <= 1'b0;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			op_q <= i_op_mode;
			slp_q <= slp_d;
		end
	end

	// conversion sequencing
	logic conv_q, conv_d, upd_ok;
	logic [1:0] ch_q, ch_d;
	logic [19:0] ctmr_q, ctmr_d;
	logic [15:0] shd_q [4];
	logic [15:0] shd_d [4];
	logic [15:0] res_q [4];
	logic [15:0] res_d [4];
	logic [2:0] setc_q, setc_d, nch;

	assign upd_ok = !talk_q && !(i_int_mode == HSM_INT_SCL_IDLE && busy_q);

	always_comb begin
		conv_d = conv_q;
		ch_d = ch_q;
		ctmr_d = ctmr_q + 20'h1;
		shd_d = shd_q;
		res_d = res_q;
		setc_d = setc_q;
		nch = next_ch(i_ch_en, 3'h0);
		if (st_q != HSM_STANDBY && st_q != HSM_MEASURE) begin
			conv_d = 1'b0;
			ctmr_d = 20'h0;
		end else if (!conv_q) begin
			ctmr_d = 20'h0;
			if ((st_q == HSM_MEASURE || i_trigger) && nch != `HSM_CH_NONE) begin
				conv_d = 1'b1;
				ch_d = nch[1:0];
			end
		end else if (ctmr_q == conv_len(i_averaging_select) - 20'h1) begin
			shd_d[ch_q] = i_adc_data;
			ctmr_d = 20'h0;
			nch = next_ch(i_ch_en, {1'b0, ch_q} + 3'h1);
			if (nch != `HSM_CH_NONE) begin
				ch_d = nch[1:0];
			end else begin
				conv_d = 1'b0;
				// skip when addressed or held off
				if (upd_ok) begin
					res_d = shd_d;
					setc_d = setc_q + 3'h1;
				end
			end
		end
		// results are lost in sleep
		if (st_q == HSM_SLEEP) begin
			for (int i = 0; i < 4; i++) begin
				res_d[i] = 16'h0000;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			conv_q <= 1'b0;
			ch_q <= 2'h0;
			ctmr_q <= 20'h0;
			setc_q <= 3'h0;
			for (int i = 0; i < 4; i++) begin
				shd_q[i] <= 16'h0000;
				res_q[i] <= 16'h0000;
			end
		end else begin
			conv_q <= conv_d;
			ch_q <= ch_d;
			ctmr_q <= ctmr_d;
			setc_q <= setc_d;
			shd_q <= shd_d;
			res_q <= res_d;
		end
	end

	// interrupt
	logic lat_q, lat_d, pls_q, pls_d, intn_q, intn_d, scloe_q, scloe_d, pin_rt, scl_rt, ev_ok;
	logic [11:0] ptmr_q, ptmr_d;

	assign pin_rt = i_int_mode == HSM_INT_PIN || i_int_mode == HSM_INT_PIN_IDLE;
	assign scl_rt = i_int_mode == HSM_INT_SCL || i_int_mode == HSM_INT_SCL_IDLE;
	assign ev_ok = i_event && (pin_rt || scl_rt)
		&& !((i_int_mode == HSM_INT_PIN_IDLE || i_int_mode == HSM_INT_SCL_IDLE) && busy_q);

	always_comb begin
		lat_d = (ev_ok && !i_int_latch_sel && !scl_rt) || (lat_q && !addr_hit);
		pls_d = pls_q;
		ptmr_d = ptmr_q + 12'h1;
		// fixed-width pulse; clock line always pulses
		if (ev_ok && (i_int_latch_sel || scl_rt)) begin
			pls_d = 1'b1;
			ptmr_d = 12'h0;
		end else if (!pls_q || ptmr_q == 12'(`HSM_INT_PULSE_CYC - 1)) begin
			pls_d = 1'b0;
			ptmr_d = 12'h0;
		end
		intn_d = !((lat_d || pls_d) && pin_rt);
		scloe_d = pls_d && scl_rt;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{lat_q, pls_q, scloe_q} <= 3'h0;
			intn_q <= 1'b1;
			ptmr_q <= 12'h0;
		end else begin
			{lat_q, pls_q, scloe_q} <= {lat_d, pls_d, scloe_d};
			intn_q <= intn_d;
			ptmr_q <= ptmr_d;
		end
	end

	assign o_scl_out = 1'b0;
	assign o_sda_out = 1'b0;
	assign o_scl_oe = scloe_q;
	assign o_sda_oe = ack_q;
	assign o_int_n = intn_q;
	assign o_ch_sel = ch_q;
	assign o_conv_busy = conv_q;
	assign {o_result_x, o_result_y, o_result_z, o_result_t} = {res_q[0], res_q[1], res_q[2], res_q[3]};
	assign o_set_count = setc_q;
	assign o_state = st_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	ack_when_awake_a: assert property (o_sda_oe |-> awake) else $error("ack outside awake modes");
	sleep_no_ack_a: assert property (st_q == HSM_SLEEP && addr_hit |=> st_q == HSM_WAKE && !ackp_q)
		else $error("sleep address handled wrong");
	pwrup_delay_a: assert property ($fell(st_q == HSM_PWRUP) |-> $past(tmr_q) == 20'(PWRUP_CYC - 1))
		else $error("power-up delay wrong");
	wake_delay_a: assert property ($fell(st_q == HSM_WAKE) |-> $past(tmr_q) == 20'(WAKE_CYC - 1))
		else $error("wake delay wrong");
	meas_delay_a: assert property ($rose(st_q == HSM_MEASURE) |-> $past(tmr_q) == 20'(MEAS_START_CYC - 1))
		else $error("measure start delay wrong");
	sleep_entry_a: assert property ($rose(st_q == HSM_SLEEP) |-> $past(scl_s_q && tmr_q == 20'(`HSM_GOSLEEP_CYC - 1)))
		else $error("sleep entry timing wrong");
	talk_blocks_upd_a: assert property (talk_q |=> $stable(o_set_count)) else $error("update while addressed");
	busy_blocks_upd_a: assert property (i_int_mode == HSM_INT_SCL_IDLE && busy_q |=> $stable(o_set_count))
		else $error("update while busy in mode 100");
	route_none_a: assert property ($past(i_int_mode) == HSM_INT_NONE |-> o_int_n && !o_scl_oe)
		else $error("interrupt with routing off");
	latch_hold_a: assert property (lat_q && !addr_hit && pin_rt |=> lat_q && !o_int_n) else $error("latch lost");
	pulse_end_a: assert property (pls_q && ptmr_q == 12'(`HSM_INT_PULSE_CYC - 1) && !ev_ok |=> !pls_q)
		else $error("pulse width wrong");

	measure_c: cover property (st_q == HSM_MEASURE && conv_q);
	wake_c: cover property (st_q == HSM_SLEEP ##1 st_q == HSM_WAKE);
	latch_clr_c: cover property (lat_q ##1 !lat_q);
	update_c: cover property (!conv_q && $changed(o_set_count));
endmodule

// *** verification/hsm_host.sv ***
// i2c host model for the hall sensor controller bench
`timescale 1ns/1ps
module hsm_host (
	// bus wire levels
	input  wire logic i_sda,
	// open-drain pulls, high pulls the line low
	output logic      o_scl_lo,
	output logic      o_sda_lo
);
	initial begin
		o_scl_lo = 1'h0;
		o_sda_lo = 1'h0;
	end

	// address phase, 160 ns bits, msb first
	task automatic addr(input logic [6:0] a, output logic ack);
		logic [7:0] b;
		b = {a, 1'h0};
		o_sda_lo = 1'h1;
		#80 o_scl_lo = 1'h1;
		for (int i = 7; i >= 0; i--) begin
			o_sda_lo = ~b[i];
			#40 o_scl_lo = 1'h0;
			#80 o_scl_lo = 1'h1;
			#40;
		end
		// sda released so the target can pull it
		o_sda_lo = 1'h0;
		#40 o_scl_lo = 1'h0;
		#40 ack = ~i_sda;
		#40 o_scl_lo = 1'h1;
		#40;
	endtask

	// clock left high afterwards, it stands still between frames
	task automatic stop();
		o_sda_lo = 1'h1;
		#40 o_scl_lo = 1'h0;
		#40 o_sda_lo = 1'h0;
		#80;
	endtask
endmodule

// *** verification/tb_hsm_ctrl.sv ***
// self-checking bench of the hall sensor mode and interrupt controller
`timescale 1ns/1ps
module tb_hsm_ctrl import hsm_pkg::*;;
	localparam logic [6:0] ADDR = 7'h2A;
	logic        i_clk, i_rst_n, trig, ev, latch, ack;
	logic        scl_oe, sda_oe, busy, int_n, scl_lo, sda_lo;
	logic [1:0]  op, e;
	logic [2:0]  imode, avg, st, cnt;
	logic [15:0] adc, rx, ry;
	logic [3:0]  chen;
	logic [1:0]  chs;
	wire         scl = ~(scl_lo | scl_oe);
	wire         sda = ~(sda_lo | sda_oe);
	int          miscompares = 0;
	int          checked = 0;
	int          n;

	// short counts keep the run brief
	hsm_ctrl #(.PWRUP_CYC(50), .WAKE_CYC(40), .MEAS_START_CYC(30), .CONV_BASE_CYC(20), .CONV_STEP_CYC(10)) dut_u (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda), .o_scl_out(), .o_scl_oe(scl_oe),
		.o_sda_out(), .o_sda_oe(sda_oe), .i_dev_addr(ADDR), .i_op_mode(op), .i_int_mode(imode),
		.i_int_latch_sel(latch), .i_averaging_select(avg), .i_ch_en(chen), .i_trigger(trig), .i_event(ev),
		.i_adc_data(adc), .o_ch_sel(chs), .o_conv_busy(busy), .o_result_x(rx), .o_result_y(ry), .o_result_z(),
		.o_result_t(), .o_set_count(cnt), .o_state(st), .o_int_n(int_n));
	hsm_host host_u (.i_sda(sda), .o_scl_lo(scl_lo), .o_sda_lo(sda_lo));

	initial begin
		i_clk = 1'h0;
		forever #2.5 i_clk = ~i_clk;
	end

	task automatic step(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic done(input string s);
		$display("test %s ended", s);
	endtask

	task automatic close_out();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// single conversion, busy length and set count
	task automatic conv(input logic [2:0] a, input int len, input logic [2:0] c);
		avg = a;
		trig = 1'h1;
		step(1);
		trig = 1'h0;
		n = 0;
		while (busy !== 1'h1 && n < 4) begin
			n++;
			step(1);
		end
		n = 0;
		while (busy === 1'h1 && n < 2000) begin
			n++;
			step(1);
		end
		chk(n, len);
		chk(cnt, c);
	endtask

	task automatic pulse_ev();
		ev = 1'h1;
		step(1);
		ev = 1'h0;
		step(1);
	endtask

	initial begin
		#400000;
		miscompares++;
		close_out();
	end

	initial begin
		{i_rst_n, trig, ev, latch, op, imode, avg} = '0;
		chen = 4'h1;
		adc = 16'h8001;
		step(16);
		chk(st, HSM_PWRUP);
		i_rst_n = 1'h1;
		step(45);
		chk(st, HSM_PWRUP);
		step(10);
		chk(st, HSM_STANDBY);
		done("powerup");
		conv(3'h0, 20, 3'h1);
		chk(rx, 16'h8001);
		adc = 16'h7FFE;
		conv(3'h5, 330, 3'h2);
		chk(rx, 16'h7FFE);
		adc = 16'h0001;
		fork
			conv(3'h5, 330, 3'h2);
			host_u.addr(ADDR, ack);
		join
		chk({ack, rx}, {1'h1, 16'h7FFE});
		host_u.stop();
		chen = 4'h3;
		adc = 16'h1234;
		fork
			conv(3'h0, 40, 3'h3);
			begin
				step(21);
				chk(chs, 2'h1);
				adc = 16'h5678;
			end
		join
		chk(rx, 16'h1234);
		chk(ry, 16'h5678);
		// mode 4: foreign traffic holds results back and masks events
		imode = 3'h4;
		adc = 16'hAAAA;
		fork
			conv(3'h0, 40, 3'h3);
			host_u.addr(ADDR ^ 7'h01, ack);
			begin
				step(10);
				pulse_ev();
				chk(scl_oe, 1'h0);
			end
		join
		host_u.stop();
		chk({ack, ry}, {1'h0, 16'h5678});
		imode = 3'h0;
		fork
			conv(3'h0, 40, 3'h4);
			host_u.addr(ADDR ^ 7'h01, ack);
		join
		host_u.stop();
		chk(ry, 16'hAAAA);
		done("conversion");
		latch = 1'h1;
		for (int m = 0; m < 5; m++) begin
			imode = m[2:0];
			e = {m != 1 && m != 2, m > 2};
			pulse_ev();
			chk({int_n, scl_oe}, e);
			step(1990);
			chk({int_n, scl_oe}, e);
			step(20);
			chk({int_n, scl_oe}, 2'h2);
		end
		imode = 3'h1;
		latch = 1'h0;
		pulse_ev();
		step(2100);
		chk(int_n, 1'h0);
		host_u.addr(ADDR, ack);
		host_u.stop();
		chk({ack, int_n}, 2'h3);
		imode = 3'h0;
		done("interrupt");
		op = 2'h2;
		step(29);
		chk(st, HSM_START_MEAS);
		step(3);
		chk(st, HSM_MEASURE);
		op = 2'h0;
		step(3);
		chk(st, HSM_STANDBY);
		done("measure");
		op = 2'h1;
		step(3);
		chk(st, HSM_GO_SLEEP);
		step(3990);
		chk(st, HSM_GO_SLEEP);
		step(20);
		chk(st, HSM_SLEEP);
		n = 0;
		fork
			begin
				host_u.addr(ADDR, ack);
				host_u.stop();
			end
			begin
				while (st !== HSM_WAKE && n < 900) begin
					n++;
					step(1);
				end
				n = 0;
				while (st === HSM_WAKE && n < 900) begin
					n++;
					step(1);
				end
			end
		join
		chk({ack, n[7:0]}, {1'h0, 8'h28});
		chk(st, HSM_STANDBY);
		host_u.addr(ADDR, ack);
		host_u.stop();
		chk(ack, 1'h1);
		op = 2'h0;
		done("sleep");
		close_out();
	end
endmodule
